// >>> inc/exec_defs.svh
// width, opcode and field constants for the table/test/xor execution unit
// assumes: included by its bare name from the package and the design files
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH
`define PTR_W            21
`define HOLD_DEPTH       8
`define HOLD_SEL_W       3
`define OP_TBL_HI        13'h0001
`define OP_TBL_WRITE_BIT 2
`define OP_XOR_HI        8'h0a
`define OP_TSTZ_HI       7'h33
`define INDEXED_MAX      8'h5f
`define TABLE_POINTER_RESET     21'h000000
`define BYTE_RESET       8'h00
`define FRAME_PTR_RESET  8'h00
`endif

// >>> inc/exec_pkg.sv
// types shared by the execution unit and its operand decoder
// assumes: exec_defs.svh on the include path
`include "exec_defs.svh"
package exec_pkg;
    typedef enum logic [1:0] {
        upd_none     = 2'b00,
        upd_post_inc = 2'b01,
        upd_post_dec = 2'b10,
        upd_pre_inc  = 2'b11
    } ptr_update_t;

    typedef enum logic [1:0] {
        st_decode    = 2'b00,
        st_table     = 2'b01,
        st_skip      = 2'b10,
        st_skip_long = 2'b11
    } exec_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [3:0] bank;
        logic       indexed;
    } reg_sel_t;

    typedef struct packed {
        logic negative;
        logic zero;
    } nz_flags_t;
endpackage : exec_pkg

// >>> verilog/operand_bank_sel.sv
// register operand resolution for file-register instructions
// assumes: caller supplies the bank pointer and frame base on core_clk
`timescale 1ns/10ps
`include "exec_defs.svh"
module operand_bank_sel
    import exec_pkg::*;
(
    // instruction fields
    input  wire logic [7:0] f_field,
    input  wire logic       access_bit,
    // configuration and bank state
    input  wire logic       extended_set_config_bit,
    input  wire logic [3:0] bank_select_pointer,
    input  wire logic [7:0] frame_base,
    // resolved operand
    output reg_sel_t        sel
);
    wire use_index = !access_bit && extended_set_config_bit
                     && (f_field <= `INDEXED_MAX);
    wire [7:0] idx_addr = 8'(frame_base + f_field);
    // access bank: low half maps to bank 0, high half to bank 15
    wire [3:0] acc_bank = f_field[7] ? 4'hf : 4'h0;
    assign sel.indexed = use_index;
    assign sel.addr    = use_index ? idx_addr : f_field;
    assign sel.bank    = access_bit ? bank_select_pointer : acc_bank;
endmodule : operand_bank_sel

// >>> verilog/table_access_test_xor_exec.sv
// execution unit for table read/write, test-and-skip and xor-literal
// assumes: one instruction word offered per core_clk cycle with instr_valid;
// program memory answers combinationally in the cycle pmem_rd_en is high
//
// Function
// - table read loads the program byte at the pointer into the table latch.
// - the table pointer is a 21-bit byte address over a 2-Mbyte space.
// - pointer bit 0 picks the low byte (0) or high byte (1) of a program word.
// - 0x000c-0x000f decode as table write, 0x0008-0x000b as table read, nn is the update mode.
// - mode 0 keeps, 1 post-increments, 2 post-decrements, 3 pre-increments the pointer.
// - table write copies the latch into one of eight holding registers chosen by pointer bits 2..0.
// - table write touches only the holding registers, never the flash array.
// - table read and write change no status flag.
// - test-and-skip turns the fetched next instruction into a no-op when the register is zero.
// - test-and-skip takes one cycle, two if skipping, three if skipping a two-word instruction.
// - access bit 0 selects the access bank, 1 uses the bank select pointer.
// - with access bit 0 and the extended set on, operands up to 0x5f are indexed offsets.
// - xor-literal xors the accumulator with the 8-bit literal into the accumulator.
// - xor-literal decodes from 0x0a in the high byte and takes one word and one cycle.
// - xor-literal updates only negative and zero flags.
// - indexed offsets exist only when the extended-set configuration bit is set.
`timescale 1ns/10ps
`include "exec_defs.svh"
module table_access_test_xor_exec
    import exec_pkg::*;
#(
    parameter int PTR_W = `PTR_W,
    parameter int HOLD_DEPTH = `HOLD_DEPTH
)(
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset,
    // instruction stream
    input  wire logic             instr_valid,
    input  wire logic [15:0]      instr_word,
    input  wire logic             next_is_two_word,
    output logic                  instr_ready,
    output logic                  discard_next,
    // configuration and bank state
    input  wire logic             extended_set_config_bit,
    input  wire logic [3:0]       bank_select_pointer,
    input  wire logic [7:0]       frame_base,
    // file register read port
    output reg_sel_t              file_sel,
    input  wire logic [7:0]       file_rdata,
    // program memory read port
    output logic                  pmem_rd_en,
    output logic [PTR_W-1:0]      pmem_addr,
    input  wire logic [7:0]       pmem_rdata,
    // holding register bank
    output logic [7:0]            holding_regs [HOLD_DEPTH],
    output logic                  hold_wr_pulse,
    // architectural state
    output logic [PTR_W-1:0]      table_pointer,
    output logic [7:0]            table_latch,
    output logic [7:0]            accumulator,
    output nz_flags_t             nz_flags,
    output logic                  nz_update
);
    exec_state_t state_q, state_d;
    logic [PTR_W-1:0] ptr_q;
    logic [7:0] latch_q, acc_q;
    logic [7:0] hold_q [HOLD_DEPTH];
    nz_flags_t nz_q;
    logic nz_upd_q, hold_pulse_q;
    logic [1:0] mode_q;
    logic is_write_q;

    function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p, input logic dec);
        ptr_step = dec ? PTR_W'(p - 1'b1) : PTR_W'(p + 1'b1);
    endfunction : ptr_step

    // decode
    wire in_decode   = (state_q == st_decode);
    wire take        = instr_valid && in_decode;
    // read (10nn) and write (11nn) share the upper thirteen bits
    wire is_tbl      = (instr_word[15:3] == `OP_TBL_HI);
    wire op_wr_bit   = instr_word[`OP_TBL_WRITE_BIT];
    wire is_xor      = (instr_word[15:8] == `OP_XOR_HI);
    wire is_tstz     = (instr_word[15:9] == `OP_TSTZ_HI);
    wire table_go    = take && is_tbl;
    wire xor_go      = take && is_xor;
    wire tstz_go     = take && is_tstz;
    wire [7:0] xor_res = acc_q ^ instr_word[7:0];
    wire reg_zero    = (file_rdata == `BYTE_RESET);

    // transfer-cycle address: pre-increment moves first
    ptr_update_t mode_e;
    assign mode_e = ptr_update_t'(mode_q);
    wire [PTR_W-1:0] access_addr = (mode_e == upd_pre_inc) ? ptr_step(ptr_q, 1'b0) : ptr_q;
    wire [PTR_W-1:0] ptr_after =
        (mode_e == upd_none)     ? ptr_q :
        (mode_e == upd_post_dec) ? ptr_step(ptr_q, 1'b1) :
                                   ptr_step(ptr_q, 1'b0);
    wire in_table = (state_q == st_table);
    wire rd_xfer  = in_table && !is_write_q;
    wire wr_xfer  = in_table && is_write_q;
    wire [`HOLD_SEL_W-1:0] hold_idx = access_addr[`HOLD_SEL_W-1:0];

    operand_bank_sel u_operand (
        .f_field                 (instr_word[7:0]),
        .access_bit              (instr_word[8]),
        .extended_set_config_bit (extended_set_config_bit),
        .bank_select_pointer     (bank_select_pointer),
        .frame_base              (frame_base),
        .sel                     (file_sel)
    );

    // sequencing
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            st_decode: begin
                if (table_go) begin
                    state_d = st_table;
                end else if (tstz_go && reg_zero) begin
                    state_d = next_is_two_word ? st_skip_long : st_skip;
                end
            end
            st_table:     state_d = st_decode;
            st_skip_long: state_d = st_skip;
            st_skip:      state_d = st_decode;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= st_decode;
            mode_q <= 2'b00;
            is_write_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (table_go) begin
                mode_q <= instr_word[1:0];
                is_write_q <= op_wr_bit;
            end
        end
    end

    // pointer and latch; no flag path here
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ptr_q <= `TABLE_POINTER_RESET;
            latch_q <= `BYTE_RESET;
        end else if (in_table) begin
            ptr_q <= ptr_after;
            if (rd_xfer) begin
                latch_q <= pmem_rdata;
            end
        end
    end

    // holding registers only; flash array is never written here
    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int i = 0; i < HOLD_DEPTH; i++) begin
                hold_q[i] <= `BYTE_RESET;
            end
            hold_pulse_q <= 1'b0;
        end else begin
            hold_pulse_q <= wr_xfer;
            if (wr_xfer) begin
                hold_q[hold_idx] <= latch_q;
            end
        end
    end

    // accumulator and n/z flags
    always_ff @(posedge core_clk) begin
        if (reset) begin
            acc_q <= `BYTE_RESET;
            nz_q <= '0;
            nz_upd_q <= 1'b0;
        end else begin
            nz_upd_q <= xor_go;
            if (xor_go) begin
                acc_q <= xor_res;
                nz_q.negative <= xor_res[7];
                nz_q.zero <= (xor_res == `BYTE_RESET);
            end
        end
    end

    // outputs
    assign instr_ready   = in_decode;
    assign discard_next  = (state_q == st_skip) || (state_q == st_skip_long);
    assign pmem_rd_en    = rd_xfer;
    assign pmem_addr     = access_addr;
    assign holding_regs  = hold_q;
    assign hold_wr_pulse = hold_pulse_q;
    assign table_pointer = ptr_q;
    assign table_latch   = latch_q;
    assign accumulator   = acc_q;
    assign nz_flags      = nz_q;
    assign nz_update     = nz_upd_q;
endmodule : table_access_test_xor_exec

// >>> sim/exec_monitor.sv
// port checker for the table/test/xor execution unit
// assumes: bound onto table_access_test_xor_exec, one clock domain
`timescale 1ns/10ps
module exec_monitor
    import exec_pkg::*;
#(
    parameter int PTR_W      = 21,
    parameter int HOLD_DEPTH = 8
)(
    // clock and reset
    input wire logic             core_clk,
    input wire logic             reset,
    // instruction stream
    input wire logic             instr_valid,
    input wire logic [15:0]      instr_word,
    input wire logic             next_is_two_word,
    input wire logic             instr_ready,
    input wire logic             discard_next,
    input wire logic [7:0]       file_rdata,
    // program memory and state
    input wire logic             pmem_rd_en,
    input wire logic [PTR_W-1:0] pmem_addr,
    input wire logic [7:0]       pmem_rdata,
    input wire logic [PTR_W-1:0] table_pointer,
    input wire logic [7:0]       table_latch,
    input wire logic [7:0]       accumulator,
    input wire nz_flags_t        nz_flags,
    input wire logic             nz_update
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    wire       take   = instr_valid && instr_ready;
    wire       is_tbl = take && instr_word[15:3] == 13'h0001;
    wire       is_xor = take && instr_word[15:8] == 8'h0a;
    wire       is_tst = take && instr_word[15:9] == 7'h33;
    wire [1:0] mode   = instr_word[1:0];
    wire [7:0] lit    = instr_word[7:0];
    logic [PTR_W-1:0] exp_ptr_d;
    logic [PTR_W-1:0] exp_ptr_q;
    // pointer expected after the transfer, held until the next table op
    assign exp_ptr_d = mode == 2'd0 ? table_pointer : mode == 2'd2 ? table_pointer - 1'b1 : table_pointer + 1'b1;
    always_ff @(posedge core_clk) if (is_tbl) exp_ptr_q <= exp_ptr_d;

    tbl_two_cycle_a: assert property (is_tbl |=> !instr_ready ##1 instr_ready) else $error("table length");
    rd_fetch_a: assert property (is_tbl && !instr_word[2] |=> pmem_rd_en
        && pmem_addr == ($past(mode) == 2'd3 ? exp_ptr_q : table_pointer)) else $error("fetch address");
    latch_load_a: assert property (pmem_rd_en |=> table_latch == $past(pmem_rdata)) else $error("latch");
    ptr_update_a: assert property (is_tbl |=> ##1 table_pointer == exp_ptr_q) else $error("pointer");
    tbl_flags_a: assert property (is_tbl |=> ##1 ($stable(nz_flags) && !nz_update)) else $error("flags");
    xor_result_a: assert property (is_xor |=> accumulator == ($past(accumulator) ^ $past(lit)) && nz_update)
        else $error("xor result");
    xor_flags_a: assert property (is_xor |=> nz_flags.zero == (accumulator == 8'h00)
        && nz_flags.negative == accumulator[7]) else $error("xor flags");
    skip_short_a: assert property (is_tst && file_rdata == 8'h00 && !next_is_two_word
        |=> discard_next ##1 !discard_next) else $error("short skip");
    skip_long_a: assert property (is_tst && file_rdata == 8'h00 && next_is_two_word
        |=> discard_next [*2] ##1 !discard_next) else $error("long skip");
    no_skip_a: assert property (is_tst && file_rdata != 8'h00 |=> !discard_next && instr_ready)
        else $error("no skip");
    cover property (is_tbl && mode == 2'd3);
    cover property (is_xor ##1 is_xor);
    cover property (is_tst && next_is_two_word && file_rdata == 8'h00);
endmodule : exec_monitor

bind table_access_test_xor_exec exec_monitor #(.PTR_W(PTR_W), .HOLD_DEPTH(HOLD_DEPTH)) mon (
    .core_clk(core_clk), .reset(reset), .instr_valid(instr_valid), .instr_word(instr_word),
    .next_is_two_word(next_is_two_word), .instr_ready(instr_ready), .discard_next(discard_next),
    .file_rdata(file_rdata), .pmem_rd_en(pmem_rd_en), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
    .table_pointer(table_pointer), .table_latch(table_latch), .accumulator(accumulator),
    .nz_flags(nz_flags), .nz_update(nz_update)
);

// >>> sim/pmem_model.sv
// program memory model answering in the cycle of the read
// assumes: driven by the execution unit's read port
`timescale 1ns/10ps
module pmem_model (
    input  wire logic        core_clk,
    input  wire logic        pmem_rd_en,
    input  wire logic [20:0] pmem_addr,
    output logic      [7:0]  pmem_rdata
);
    logic [7:0] last_q = 8'h00;
    // idle bus shows the inverse of the last byte so stale data never matches
    assign pmem_rdata = pmem_rd_en ? pmem_addr[7:0] ^ 8'h3c : ~last_q;
    always_ff @(posedge core_clk) last_q <= pmem_rdata;
endmodule : pmem_model

// >>> sim/table_access_test_xor_exec_test.sv
// self-checking bench for the execution unit
// assumes: exec_monitor and pmem_model compiled before it
`timescale 1ns/10ps
module table_access_test_xor_exec_test;
    import exec_pkg::*;
    logic core_clk = 0, reset = 1, instr_valid = 0, next_is_two_word = 0, extended_set_config_bit = 0;
    logic [15:0] instr_word = 16'h0000;
    logic [3:0]  bank_select_pointer = 4'h5;
    logic [7:0]  frame_base = 8'h10, file_rdata = 8'h00, pmem_rdata, table_latch, accumulator;
    logic [20:0] pmem_addr, table_pointer;
    logic        instr_ready, discard_next, pmem_rd_en, hold_wr_pulse, nz_update;
    logic [7:0]  holding_regs [8];
    reg_sel_t    file_sel;
    nz_flags_t   nz_flags;
    int          n_mismatch = 0, checks_done = 0;

    table_access_test_xor_exec DUT (
        .core_clk(core_clk), .reset(reset), .instr_valid(instr_valid), .instr_word(instr_word),
        .next_is_two_word(next_is_two_word), .instr_ready(instr_ready), .discard_next(discard_next),
        .extended_set_config_bit(extended_set_config_bit), .bank_select_pointer(bank_select_pointer),
        .frame_base(frame_base), .file_sel(file_sel), .file_rdata(file_rdata),
        .pmem_rd_en(pmem_rd_en), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
        .holding_regs(holding_regs), .hold_wr_pulse(hold_wr_pulse), .table_pointer(table_pointer),
        .table_latch(table_latch), .accumulator(accumulator), .nz_flags(nz_flags), .nz_update(nz_update)
    );
    pmem_model mem (
        .core_clk(core_clk), .pmem_rd_en(pmem_rd_en), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata)
    );

    initial forever #5 core_clk = ~core_clk;

    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    // one take at the next rising edge; returns at the falling edge after it
    // hold keeps valid up so a following issue never lowers and raises it in one step
    task automatic issue(input logic [15:0] w, input logic hold = 1'b0);
        instr_word = w;
        instr_valid = 1;
        @(negedge core_clk);
        if (!hold) begin
            instr_valid = 0;
        end
    endtask : issue

    task automatic t_xor;
        issue(16'h0a80, 1'b1);
        chk(accumulator, 8'h80);
        chk(nz_flags, 2'b10);
        issue(16'h0aff, 1'b1);
        issue(16'h0a7f);
        chk(accumulator, 8'h00);
        chk(nz_flags, 2'b01);
        $display("xor test done");
        @(negedge core_clk);
    endtask : t_xor

    task automatic t_table;
        logic [20:0] p;
        logic [7:0]  l;
        logic [15:0] ops [8] = '{16'h000a, 16'h000b, 16'h0009, 16'h0008, 16'h000d, 16'h000f, 16'h000e, 16'h000c};
        p = 21'h000000;
        l = 8'h00;
        // starts at pointer zero so the first decrement wraps the 21-bit space
        foreach (ops[i]) begin
            issue(ops[i]);
            @(negedge core_clk);
            chk(hold_wr_pulse, ops[i][2]);
            @(negedge core_clk);
            if (ops[i][1:0] == 2'd3) p++;
            if (!ops[i][2]) l = p[7:0] ^ 8'h3c;
            else chk(holding_regs[p[2:0]], l);
            if (ops[i][1:0] == 2'd1) p++;
            if (ops[i][1:0] == 2'd2) p--;
            chk(table_pointer, p);
            chk(table_latch, l);
            chk(nz_flags, 2'b01);
        end
        $display("table test done");
    endtask : t_table

    task automatic tst_one(input logic [15:0] w, input logic e, input logic t, input logic [7:0] d,
                           input reg_sel_t s, input logic [1:0] nd);
        logic [1:0] n;
        extended_set_config_bit = e;
        next_is_two_word = t;
        file_rdata = d;
        n = 2'd0;
        issue(w);
        // word still stands after the take, so the operand select is still settled
        chk(file_sel.addr, s.addr);
        chk(file_sel.indexed, s.indexed);
        if (!s.indexed) chk(file_sel.bank, s.bank);
        repeat (4) begin
            if (discard_next === 1'b1) n++;
            @(negedge core_clk);
        end
        chk(n, nd);
    endtask : tst_one

    task automatic t_skip;
        tst_one(16'h6720, 0, 0, 8'h00, '{8'h20, 4'h5, 1'b0}, 2'd1);
        tst_one(16'h6690, 1, 1, 8'h00, '{8'h90, 4'hf, 1'b0}, 2'd2);
        tst_one(16'h665f, 1, 0, 8'h07, '{8'h6f, 4'h0, 1'b1}, 2'd0);
        tst_one(16'h665f, 0, 0, 8'h00, '{8'h5f, 4'h0, 1'b0}, 2'd1);
        $display("skip test done");
    endtask : t_skip

    initial begin
        repeat (5) @(negedge core_clk);
        reset = 0;
        t_xor;
        t_table;
        t_skip;
        wrap_up;
    end

    // all tests need well under a thousand cycles
    initial begin
        #20us;
        n_mismatch++;
        wrap_up;
    end
endmodule : table_access_test_xor_exec_test
